// ---- hdl/dms_defs.svh ----
// Constants for the DLL mode switch sequencer: pin codes, mode register fields, timings.
`ifndef DMS_DEFS_SVH
`define DMS_DEFS_SVH

// Controller clock period in picoseconds (20 MHz).
`define DMS_CLK_PERIOD_PS 50000

// Nanoseconds to whole clock cycles, always rounded up.
`define DMS_NS_TO_NCK(ns) ((((ns) * 1000) + `DMS_CLK_PERIOD_PS - 1) / `DMS_CLK_PERIOD_PS)
`define DMS_MAX(a, b) (((a) > (b)) ? (a) : (b))

// Command codes as {cs_n, ras_n, cas_n, we_n}.
`define DMS_CMD_MODE_SET 4'h0
`define DMS_CMD_SELF_REFRESH 4'h1
`define DMS_CMD_LONG_CAL 4'h6
`define DMS_CMD_NOP 4'h7

// Bank address of each mode register.
`define DMS_BA_MODE_REGISTER_ZERO 3'h0
`define DMS_BA_MODE_REGISTER_ONE 3'h1
`define DMS_BA_MODE_REGISTER_TWO 3'h2
`define DMS_BA_MODE_REGISTER_THREE 3'h3

// Mode register field positions and codes.
`define DMS_DLL_DISABLE_BIT 0
`define DMS_DLL_RESET_BIT 8
`define DMS_LONG_CAL_BIT 10
`define DMS_READ_LATENCY_MASK 16'h0074
`define DMS_READ_LATENCY_SIX 16'h0020
`define DMS_WRITE_LATENCY_MASK 16'h0038
`define DMS_WRITE_LATENCY_SIX 16'h0008

// Timing figures, each in its own unit (ns or clock_cycle_unit).
`define DMS_MODE_SET_DELAY_NS 15
`define DMS_MODE_SET_DELAY_MIN_NCK 12
`define DMS_MODE_COMMAND_SPACING_NCK 4
`define DMS_SR_ENTRY_CLOCK_HOLD_NS 10
`define DMS_SR_ENTRY_CLOCK_HOLD_MIN_NCK 5
`define DMS_SR_EXIT_CLOCK_SETUP_NS 10
`define DMS_SR_EXIT_CLOCK_SETUP_MIN_NCK 5
`define DMS_SR_EXIT_DELAY_NS 100
`define DMS_SR_EXIT_DELAY_MIN_NCK 5
`define DMS_DLL_LOCK_TIME_NCK 512
`define DMS_LONG_CALIBRATION_TIME_NCK 256

`endif

// ---- hdl/dms_pkg.sv ----
// Types shared by the DLL mode switch sequencer files.
package dms_pkg;

    // Gray codes along the usual path of a transition up to DMS_DONE.
    typedef enum logic [4:0] {
        DMS_IDLE       = 5'h00,
        DMS_MR1_OFF    = 5'h01,
        DMS_WAIT_MOD   = 5'h03,
        DMS_SRE        = 5'h02,
        DMS_WAIT_SRE   = 5'h06,
        DMS_FREQ       = 5'h07,
        DMS_WAIT_SETUP = 5'h05,
        DMS_SRX        = 5'h04,
        DMS_WAIT_XS    = 5'h0C,
        DMS_MRS        = 5'h0D,
        DMS_WAIT_MRS   = 5'h0F,
        DMS_ZQ         = 5'h0E,
        DMS_FINAL      = 5'h0A,
        DMS_DONE       = 5'h0B
    } dms_state_e;

    typedef logic [9:0]  dms_count_t;
    typedef logic [15:0] dms_addr_t;

endpackage

// ---- hdl/dms_wait_counter.sv ----
// Loadable down counter that marks when a wait of a given number of clock edges is over.
`timescale 1ns/1ps
`default_nettype none

module dms_wait_counter (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              load_i,
    input  wire dms_pkg::dms_count_t count_i,
    output logic                   done_o
);

    dms_pkg::dms_count_t rem_q;

    // A load of N reports done N edges later; a count of zero behaves as one.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rem_q <= '0;
        end else if (load_i) begin
            rem_q <= (count_i == '0) ? '0 : dms_pkg::dms_count_t'(count_i - 10'h001);
        end else if (rem_q != '0) begin
            rem_q <= dms_pkg::dms_count_t'(rem_q - 10'h001);
        end
    end

    assign done_o = (rem_q == '0);

endmodule // dms_wait_counter

`default_nettype wire

// ---- hdl/dms_sequencer.sv ----
// Controller-side sequencer that switches the memory DLL off or on around a clock change.
//
// What this block does
// - Clock frequency changes only while the memory sits in self refresh.
// - Before the DLL-disable write: banks idle, timings met, termination off.
// - After DLL-disable write wait mode-set delay, enter self refresh, wait entry hold.
// - New clock stable for the exit clock setup time before self-refresh exit.
// - DLL-off: clock enable high from self-refresh exit until all mode-set delays end.
// - DLL-off: termination pin low until all mode-set delays end.
// - DLL-off: wait self-refresh exit delay, rewrite mode registers, optional long calibration.
// - After final DLL-off mode write, wait mode-set delay before any command.
// - DLL-on: idle and termination off before self refresh, then wait entry hold.
// - DLL-on: clock enable high from self-refresh exit until DLL lock time ends.
// - DLL-on: termination pin low until DLL lock time after DLL reset ends.
// - DLL-on: wait self-refresh exit delay, then clear the DLL-disable bit.
// - After DLL enable, wait command spacing, then set the DLL-reset bit.
// - Another spacing, remaining registers, then long calibration after mode-set delay.
// - Withhold locked-DLL commands until lock time and long calibration time pass.
// - Waits count real clock edges; mode writes spaced five edges apart.
// - Nanosecond timings become cycle counts, rounded up to whole cycles.
`timescale 1ns/1ps
`default_nettype none

`include "dms_defs.svh"

module dms_sequencer (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // User side.
    input  wire logic              start_i,
    input  wire logic              dll_on_i,
    input  wire logic              long_cal_en_i,
    input  wire dms_pkg::dms_addr_t mr0_i,
    input  wire dms_pkg::dms_addr_t mr1_i,
    input  wire dms_pkg::dms_addr_t mr2_i,
    input  wire dms_pkg::dms_addr_t mr3_i,
    input  wire logic              clk_stable_i,
    input  wire logic              user_cke_i,
    input  wire logic              user_odt_i,
    output logic                   busy_o,
    output logic                   done_o,
    output logic                   freq_change_o,
    output logic                   dll_off_o,
    // Memory pins.
    output logic                   cke_o,
    output logic                   termination_control_pin_o,
    output logic                   cs_n_o,
    output logic                   ras_n_o,
    output logic                   cas_n_o,
    output logic                   we_n_o,
    output logic [2:0]             ba_o,
    output dms_pkg::dms_addr_t     addr_o
);

    // Wait lengths in cycles; nanosecond figures round up, then meet the cycle minimum.
    localparam dms_pkg::dms_count_t MOD_NCK = dms_pkg::dms_count_t'(`DMS_MAX(
        `DMS_MODE_SET_DELAY_MIN_NCK, `DMS_NS_TO_NCK(`DMS_MODE_SET_DELAY_NS)));
    localparam dms_pkg::dms_count_t MRD_NCK =
        dms_pkg::dms_count_t'(`DMS_MODE_COMMAND_SPACING_NCK);
    localparam dms_pkg::dms_count_t CKSRE_NCK = dms_pkg::dms_count_t'(`DMS_MAX(
        `DMS_SR_ENTRY_CLOCK_HOLD_MIN_NCK, `DMS_NS_TO_NCK(`DMS_SR_ENTRY_CLOCK_HOLD_NS)));
    localparam dms_pkg::dms_count_t CKSRX_NCK = dms_pkg::dms_count_t'(`DMS_MAX(
        `DMS_SR_EXIT_CLOCK_SETUP_MIN_NCK, `DMS_NS_TO_NCK(`DMS_SR_EXIT_CLOCK_SETUP_NS)));
    localparam dms_pkg::dms_count_t XS_NCK = dms_pkg::dms_count_t'(`DMS_MAX(
        `DMS_SR_EXIT_DELAY_MIN_NCK, `DMS_NS_TO_NCK(`DMS_SR_EXIT_DELAY_NS)));
    localparam dms_pkg::dms_count_t DLLK_NCK =
        dms_pkg::dms_count_t'(`DMS_DLL_LOCK_TIME_NCK);
    localparam dms_pkg::dms_count_t ZQ_NCK =
        dms_pkg::dms_count_t'(`DMS_LONG_CALIBRATION_TIME_NCK);

    dms_pkg::dms_state_e state_q;
    dms_pkg::dms_state_e state_d;
    logic                dll_on_q;
    logic                long_cal_q;
    logic [1:0]          idx_q;
    logic [1:0]          last_idx;
    logic [2:0]          mrs_ba;
    dms_pkg::dms_addr_t  mrs_addr;
    logic                step_load;
    dms_pkg::dms_count_t step_count;
    logic                step_done;
    logic                lock_load;
    logic                lock_done;
    logic                zq_load;
    logic                zq_done;
    logic                mrs_on_pins;

    // One counter per overlapping wait: the current step, DLL locking, long calibration.
    dms_wait_counter u_step_wait (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (step_load),
        .count_i (step_count),
        .done_o  (step_done)
    );

    dms_wait_counter u_lock_wait (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (lock_load),
        .count_i (DLLK_NCK),
        .done_o  (lock_done)
    );

    dms_wait_counter u_zq_wait (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (zq_load),
        .count_i (ZQ_NCK),
        .done_o  (zq_done)
    );

    assign last_idx = dll_on_q ? 2'h3 : 2'h2;

    // Mode value for the current slot of the rewrite list.
    always_comb begin
        mrs_ba   = `DMS_BA_MODE_REGISTER_THREE;
        mrs_addr = mr3_i;
        if (dll_on_q) begin
            case (idx_q)
                2'h0: begin
                    mrs_ba                         = `DMS_BA_MODE_REGISTER_ONE;
                    mrs_addr                       = mr1_i;
                    mrs_addr[`DMS_DLL_DISABLE_BIT] = 1'b0;
                end
                2'h1: begin
                    mrs_ba                       = `DMS_BA_MODE_REGISTER_ZERO;
                    mrs_addr                     = mr0_i;
                    mrs_addr[`DMS_DLL_RESET_BIT] = 1'b1;
                end
                2'h2: begin
                    mrs_ba   = `DMS_BA_MODE_REGISTER_TWO;
                    mrs_addr = mr2_i;
                end
                default: begin
                    mrs_ba   = `DMS_BA_MODE_REGISTER_THREE;
                    mrs_addr = mr3_i;
                end
            endcase
        end else begin
            case (idx_q)
                2'h0: begin
                    mrs_ba   = `DMS_BA_MODE_REGISTER_ZERO;
                    mrs_addr = (mr0_i & ~`DMS_READ_LATENCY_MASK) | `DMS_READ_LATENCY_SIX;
                    mrs_addr[`DMS_DLL_RESET_BIT] = 1'b0;
                end
                2'h1: begin
                    mrs_ba   = `DMS_BA_MODE_REGISTER_TWO;
                    mrs_addr = (mr2_i & ~`DMS_WRITE_LATENCY_MASK) | `DMS_WRITE_LATENCY_SIX;
                end
                default: begin
                    mrs_ba   = `DMS_BA_MODE_REGISTER_THREE;
                    mrs_addr = mr3_i;
                end
            endcase
        end
    end

    // Next state and wait loads; each step wait must expire before the next step, lock and calibration waits before done.
    always_comb begin
        state_d    = state_q;
        step_load  = 1'b0;
        step_count = MOD_NCK;
        lock_load  = 1'b0;
        zq_load    = 1'b0;
        case (state_q)
            dms_pkg::DMS_IDLE: begin
                if (start_i) begin
                    state_d = dll_on_i ? dms_pkg::DMS_SRE : dms_pkg::DMS_MR1_OFF;
                end
            end
            dms_pkg::DMS_MR1_OFF: begin
                step_load  = 1'b1;
                step_count = MOD_NCK;
                state_d    = dms_pkg::DMS_WAIT_MOD;
            end
            dms_pkg::DMS_WAIT_MOD: begin
                if (step_done) begin
                    state_d = dms_pkg::DMS_SRE;
                end
            end
            dms_pkg::DMS_SRE: begin
                step_load  = 1'b1;
                step_count = CKSRE_NCK;
                state_d    = dms_pkg::DMS_WAIT_SRE;
            end
            dms_pkg::DMS_WAIT_SRE: begin
                if (step_done) begin
                    state_d = dms_pkg::DMS_FREQ;
                end
            end
            dms_pkg::DMS_FREQ: begin
                if (clk_stable_i) begin
                    step_load  = 1'b1;
                    step_count = CKSRX_NCK;
                    state_d    = dms_pkg::DMS_WAIT_SETUP;
                end
            end
            dms_pkg::DMS_WAIT_SETUP: begin
                if (step_done) begin
                    state_d = dms_pkg::DMS_SRX;
                end
            end
            dms_pkg::DMS_SRX: begin
                step_load  = 1'b1;
                step_count = XS_NCK;
                state_d    = dms_pkg::DMS_WAIT_XS;
            end
            dms_pkg::DMS_WAIT_XS: begin
                if (step_done) begin
                    state_d = dms_pkg::DMS_MRS;
                end
            end
            dms_pkg::DMS_MRS: begin
                step_load  = 1'b1;
                step_count = (idx_q == last_idx) ? MOD_NCK : MRD_NCK;
                lock_load  = dll_on_q && (idx_q == 2'h1);
                state_d    = dms_pkg::DMS_WAIT_MRS;
            end
            dms_pkg::DMS_WAIT_MRS: begin
                if (step_done) begin
                    if (idx_q != last_idx) begin
                        state_d = dms_pkg::DMS_MRS;
                    end else if (long_cal_q) begin
                        state_d = dms_pkg::DMS_ZQ;
                    end else begin
                        state_d = dms_pkg::DMS_FINAL;
                    end
                end
            end
            dms_pkg::DMS_ZQ: begin
                zq_load = 1'b1;
                state_d = dms_pkg::DMS_FINAL;
            end
            dms_pkg::DMS_FINAL: begin
                if (lock_done && zq_done) begin
                    state_d = dms_pkg::DMS_DONE;
                end
            end
            dms_pkg::DMS_DONE: begin
                state_d = dms_pkg::DMS_IDLE;
            end
            default: begin
                state_d = dms_pkg::DMS_IDLE;
            end
        endcase
    end

    // State register and the options captured when a transition starts.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q    <= dms_pkg::DMS_IDLE;
            dll_on_q   <= 1'b0;
            long_cal_q <= 1'b0;
            idx_q      <= 2'h0;
        end else begin
            state_q <= state_d;
            if (state_q == dms_pkg::DMS_IDLE && start_i) begin
                dll_on_q   <= dll_on_i;
                long_cal_q <= long_cal_en_i;
            end
            if (state_q == dms_pkg::DMS_WAIT_XS) begin
                idx_q <= 2'h0;
            end else if (state_q == dms_pkg::DMS_WAIT_MRS && step_done && idx_q != last_idx) begin
                idx_q <= 2'(idx_q + 2'h1);
            end
        end
    end

    // Command pins: a command stands for exactly one cycle, NOP otherwise.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= `DMS_CMD_NOP;
            ba_o   <= 3'h0;
            addr_o <= 16'h0000;
        end else begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= `DMS_CMD_NOP;
            ba_o   <= 3'h0;
            addr_o <= 16'h0000;
            case (state_q)
                dms_pkg::DMS_MR1_OFF: begin
                    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= `DMS_CMD_MODE_SET;
                    ba_o   <= `DMS_BA_MODE_REGISTER_ONE;
                    addr_o <= mr1_i | (16'h0001 << `DMS_DLL_DISABLE_BIT);
                end
                dms_pkg::DMS_SRE: begin
                    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= `DMS_CMD_SELF_REFRESH;
                end
                dms_pkg::DMS_MRS: begin
                    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= `DMS_CMD_MODE_SET;
                    ba_o   <= mrs_ba;
                    addr_o <= mrs_addr;
                end
                dms_pkg::DMS_ZQ: begin
                    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= `DMS_CMD_LONG_CAL;
                    addr_o <= 16'h0001 << `DMS_LONG_CAL_BIT;
                end
                default: begin
                    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= `DMS_CMD_NOP;
                end
            endcase
        end
    end

    // Clock enable drops with self-refresh entry and rises at its exit, or in idle at start or with the user.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cke_o <= 1'b0;
        end else if (state_q == dms_pkg::DMS_IDLE) begin
            // A mode write or self-refresh entry only counts with clock enable already high.
            cke_o <= start_i ? 1'b1 : user_cke_i;
        end else if (state_q == dms_pkg::DMS_SRE) begin
            cke_o <= 1'b0;
        end else if (state_q == dms_pkg::DMS_SRX) begin
            cke_o <= 1'b1;
        end
    end

    // Termination is held low for the whole transition, whatever it was set to;
    // this covers both the enabled and the disabled case at no cost.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            termination_control_pin_o <= 1'b0;
        end else if (state_q == dms_pkg::DMS_IDLE && !start_i) begin
            termination_control_pin_o <= user_odt_i;
        end else begin
            termination_control_pin_o <= 1'b0;
        end
    end

    // Status toward the user; busy covers lock and calibration time.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_o        <= 1'b0;
            done_o        <= 1'b0;
            freq_change_o <= 1'b0;
            dll_off_o     <= 1'b0;
        end else begin
            busy_o        <= (state_d != dms_pkg::DMS_IDLE);
            done_o        <= (state_q == dms_pkg::DMS_DONE);
            freq_change_o <= (state_d == dms_pkg::DMS_FREQ);
            if (state_q == dms_pkg::DMS_DONE) begin
                dll_off_o <= !dll_on_q;
            end
        end
    end

    assign mrs_on_pins = ({cs_n_o, ras_n_o, cas_n_o, we_n_o} == `DMS_CMD_MODE_SET);

    // The clock may only be changed while the memory is held in self refresh.
    freq_in_sr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        freq_change_o |-> !cke_o)
        else $error("Clock change requested outside self refresh.");

    // Frequency change waits the entry hold after self-refresh entry.
    sre_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(freq_change_o) |-> $past(!cke_o, 5) && !$past(freq_change_o, 5))
        else $error("Clock change started before entry hold elapsed.");

    // Self-refresh exit comes at least the setup time after the clock change ended.
    srx_setup_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(cke_o) && state_q == dms_pkg::DMS_WAIT_XS
        |-> $past(!cke_o, 5) && !$past(freq_change_o, 4))
        else $error("Self-refresh exit before exit clock setup.");

    // DLL-disable write only with termination low and clock enable high.
    dll_off_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mrs_on_pins && ba_o == `DMS_BA_MODE_REGISTER_ONE && addr_o[`DMS_DLL_DISABLE_BIT]
        |-> !termination_control_pin_o && cke_o)
        else $error("DLL-disable write with termination active.");

    // Clock enable and termination hold once self refresh has been left.
    cke_odt_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_q inside {dms_pkg::DMS_WAIT_XS, dms_pkg::DMS_MRS, dms_pkg::DMS_WAIT_MRS,
                        dms_pkg::DMS_ZQ, dms_pkg::DMS_FINAL}
        |-> cke_o && !termination_control_pin_o)
        else $error("Clock enable or termination changed before waits ended.");

    // No mode write within the exit delay after self-refresh exit.
    xs_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(cke_o) && state_q == dms_pkg::DMS_WAIT_XS |-> !mrs_on_pins [*5])
        else $error("Mode write inside the self-refresh exit delay.");

    // Mode writes are at least four edges apart.
    mrs_spacing_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mrs_on_pins |=> !mrs_on_pins [*3])
        else $error("Mode writes closer than four cycles.");

    // DLL reset follows the DLL enable write by the command spacing plus the
    // one decision cycle that every wait spends before the next step.
    dll_reset_order_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mrs_on_pins && ba_o == `DMS_BA_MODE_REGISTER_ZERO && addr_o[`DMS_DLL_RESET_BIT]
        |-> $past(mrs_on_pins, 5) && $past(ba_o, 5) == `DMS_BA_MODE_REGISTER_ONE)
        else $error("DLL reset not spaced after DLL enable.");

    // Read latency of six is programmed on the way into DLL-off mode.
    latency_six_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mrs_on_pins && busy_o && !dll_on_q && ba_o == `DMS_BA_MODE_REGISTER_ZERO
        |-> (addr_o & `DMS_READ_LATENCY_MASK) == `DMS_READ_LATENCY_SIX)
        else $error("Read latency not six in DLL-off mode.");

    // Completion only after DLL lock and long calibration have both run out.
    lock_before_done_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(done_o) |-> $past(lock_done, 2) && $past(zq_done, 2) && cke_o)
        else $error("Transition finished before lock or calibration time.");

endmodule // dms_sequencer

`default_nettype wire

// ---- verif/dms_mem_model.sv ----
// Behavioural memory model that follows mode writes and self refresh on the command pins.
`timescale 1ns/1ps
`default_nettype none
`include "dms_defs.svh"
module dms_mem_model (
    input  wire logic        clk_i,
    input  wire logic        cke_i,
    input  wire logic [3:0]  cmd_i,
    input  wire logic [2:0]  ba_i,
    input  wire logic [15:0] addr_i,
    output logic             dll_off_o,
    output logic             in_sr_o,
    output logic [7:0]       fault_o
);
    int gap = 99;
    initial begin
        dll_off_o = 1'b0;
        in_sr_o = 1'b0;
        fault_o = 8'h00;
    end
    // A real part ignores badly spaced writes, so each one is counted as a fault here.
    always @(posedge clk_i) begin
        gap <= gap + 1;
        if (in_sr_o && cke_i) in_sr_o <= 1'b0;
        else if (!cke_i && cmd_i == `DMS_CMD_SELF_REFRESH) in_sr_o <= 1'b1;
        if (cke_i && cmd_i == `DMS_CMD_MODE_SET) begin
            gap <= 1;
            if (gap < `DMS_MODE_COMMAND_SPACING_NCK) fault_o <= fault_o + 8'h01;
            if (ba_i == 3'h1) dll_off_o <= addr_i[`DMS_DLL_DISABLE_BIT];
            if (dll_off_o && ba_i == 3'h0 && (addr_i & 16'h0074) != 16'h0020) fault_o <= 8'hff;
            if (dll_off_o && ba_i == 3'h2 && (addr_i & 16'h0038) != 16'h0008) fault_o <= 8'hff;
        end
    end
endmodule // dms_mem_model
`default_nettype wire

// ---- verif/dram_dll_mode_switch_sequence_tb.sv ----
// Self-checking bench that runs DLL off and on transitions against the memory model.
`timescale 1ns/1ps
`default_nettype none
module dram_dll_mode_switch_sequence_tb;
    logic clk = 0, rst_n = 0, start = 0, on = 0, cal = 0, stab = 0, ucke = 0, uodt = 0;
    logic [15:0] mr0 = 0, mr1 = 0, mr2 = 0, mr3 = 0, addr;
    logic busy, done, frq, doff, cke, term, csn, rasn, casn, wen, m_off, in_sr, sr_seen = 0;
    logic [2:0] ba;
    logic [7:0] fault;
    int err_count = 0, n_tests = 0, seed = 32690, pin_bad = 0;
    always #25 clk = ~clk;
    dms_sequencer dut (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .dll_on_i(on),
        .long_cal_en_i(cal), .mr0_i(mr0), .mr1_i(mr1), .mr2_i(mr2), .mr3_i(mr3),
        .clk_stable_i(stab), .user_cke_i(ucke), .user_odt_i(uodt), .busy_o(busy),
        .done_o(done), .freq_change_o(frq), .dll_off_o(doff), .cke_o(cke),
        .termination_control_pin_o(term), .cs_n_o(csn), .ras_n_o(rasn), .cas_n_o(casn),
        .we_n_o(wen), .ba_o(ba), .addr_o(addr));
    dms_mem_model mem (.clk_i(clk), .cke_i(cke), .cmd_i({csn, rasn, casn, wen}), .ba_i(ba),
        .addr_i(addr), .dll_off_o(m_off), .in_sr_o(in_sr), .fault_o(fault));
    // Termination must stay low and clock enable high after exit, while the sequencer is busy.
    always @(posedge clk) begin
        if (busy && term) pin_bad++;
        if (busy && sr_seen && !in_sr && !cke) pin_bad++;
        sr_seen <= busy && (sr_seen || in_sr);
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One transition; a second start while busy must be ignored.
    task automatic run(input logic want_on, input logic want_cal);
        int n;
        @(negedge clk);
        {mr0, mr1, mr2, mr3} = {$random(seed), $random(seed)};
        {ucke, uodt} = 2'($random(seed));
        on = want_on;
        cal = want_cal;
        start = 1;
        @(negedge clk);
        start = 0;
        on = !want_on;
        @(negedge clk);
        start = 1;
        @(negedge clk);
        start = 0;
        n = 0;
        while (!frq && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("memory in self refresh", 1, in_sr);
        check("cke at clock change", 0, cke);
        repeat ($random(seed) & 7) @(negedge clk);
        stab = 1;
        n = 0;
        while (!done && n < 2000) begin
            @(negedge clk);
            n++;
        end
        stab = 0;
        check("done pulse", 1, done);
        check("final wait long enough", 1, n >= (want_on ? 512 : (want_cal ? 256 : 12)));
        check("dll off flag", !want_on, doff);
        check("memory dll state", !want_on, m_off);
        check("memory faults", 0, fault);
        check("pin level faults", 0, 16'(pin_bad));
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        check("busy after reset", 0, busy);
        check("dll off after reset", 0, doff);
        for (int i = 0; i < 6; i++) run(i[0], 1'($random(seed)));
        give_verdict;
    end
    // A hang is cut off well past six worst-case transitions.
    initial begin
        #1000000;
        err_count++;
        give_verdict;
    end
endmodule // dram_dll_mode_switch_sequence_tb
`default_nettype wire
